// ### csic_pkg.sv
/*
 * Constants for the processor slowdown and idle control block.
 * Assumes a single system clock and a plain register port with 8-bit data.
 */
//Operation
//R1: Idle bit picks clock-gate or full sleep
//R2: Slowdown bit throttles execution to chosen ratio
//R3: Ratio codes 0-7 give 1:2 to 1:256
//R4: Interrupt entry clears slowdown when enabled
//R5: Interrupt return sets slowdown when enabled
//R6: Peripheral clocks run; fetch precedes execute cycle
//R7: Debug forces full speed, stored bit kept
//R8: Idle bit resets on power-on only; the code also clears it on a brown-out reset
//R9: Cycle counter restarts on enable or ratio
package csic_pkg;

	localparam int         ADDR_W          = 4;
	localparam int         DATA_W          = 8;
	localparam int         RATIO_W         = 3;
	localparam int         CNT_W           = 8;
	localparam logic [3:0] CTRL_OFFSET     = 4'h0;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         BIT_IDLE_SEL    = 7;
	localparam int         BIT_SLOW_EN     = 6;
	localparam int         BIT_IRQ_FULL    = 5;
	localparam int         BIT_EXIT_SLOW   = 4;
	localparam int         RATIO_LSB       = 0;
	localparam int         RATIO_MSB       = 2;

	typedef enum logic [1:0]
	{
		ST_RUN   = 2'b00,
		ST_IDLE  = 2'b01,
		ST_SLEEP = 2'b10
	} csic_state_t;

	// Last count of a slowdown period: the period is two to the power of (code + 1).
	function automatic logic [CNT_W-1:0] last_count(input logic [RATIO_W-1:0] ratio);
		logic [CNT_W:0] span;
		span = (9'h002 << ratio) - 9'h001; // [R3]
		return span[CNT_W-1:0];
	endfunction

endpackage

// ### csic_ratio_if.sv
/*
 * Link between the control top and its slowdown cycle counter.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface csic_ratio_if;
	logic                          enable;
	logic                          restart;
	logic [csic_pkg::RATIO_W-1:0] ratio;
	logic                          exec_cycle;
	logic                          fetch_cycle;

	modport ctrl
	(
		output enable,
		output restart,
		output ratio,
		input  exec_cycle,
		input  fetch_cycle
	);

	modport cnt
	(
		input  enable,
		input  restart,
		input  ratio,
		output exec_cycle,
		output fetch_cycle
	);
endinterface
`default_nettype wire

// ### csic_ratio_cnt.sv
/*
 * Slowdown cycle counter: marks the one executed cycle in each period and the fetch cycle before it.
 * Assumes a synchronous active-low reset and the controller driving restart on an enable rise or any ratio change.
 */
`timescale 1ns/100ps
`default_nettype none
module csic_ratio_cnt
(
	// Clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	// Counter link
	csic_ratio_if.cnt  lnk
);
	logic [csic_pkg::CNT_W-1:0] cnt_q;
	logic [csic_pkg::CNT_W-1:0] cnt_d;
	logic [csic_pkg::CNT_W-1:0] last;
	wire                         at_last;

	assign last    = csic_pkg::last_count(lnk.ratio);
	assign at_last = (cnt_q == last);
	assign cnt_d   = (lnk.restart || !lnk.enable || at_last) ? '0 : cnt_q + 8'h01; // [R9]

	// Without slowdown every cycle executes and fetches.
	assign lnk.exec_cycle  = !lnk.enable || (cnt_q == '0); // [R2]
	assign lnk.fetch_cycle = !lnk.enable || at_last;       // [R6]

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule
`default_nettype wire

// ### csic_top.sv
/*
 * Processor slowdown and idle control: one control register, execution throttle, sleep gating.
 * Assumes core events arrive as one-cycle pulses synchronous to I_CLK, and I_POR_BOR is high
 * while the reset stems from power-on or brown-out.
 */
`timescale 1ns/100ps
`default_nettype none
module csic_top
(
	// Clock and reset
	input  wire logic                        I_CLK,
	input  wire logic                        I_RST_N,
	input  wire logic                        I_POR_BOR,
	// Register port
	input  wire logic [csic_pkg::ADDR_W-1:0] I_ADDR,
	input  wire logic [csic_pkg::DATA_W-1:0] I_WDATA,
	input  wire logic                        I_WR,
	input  wire logic                        I_RD,
	output logic      [csic_pkg::DATA_W-1:0] O_RDATA,
	// Processor core, interrupt controller and debugger
	input  wire logic                        I_SLEEP_EXEC,
	input  wire logic                        I_WAKE,
	input  wire logic                        I_IRQ_ENTRY,
	input  wire logic                        I_RETURN_FROM_INTERRUPT,
	input  wire logic                        I_IN_CIRCUIT_DEBUG,
	// Clock and execution enables
	output logic                             O_CPU_EXEC_EN,
	output logic                             O_PROGRAM_MEMORY_FETCH_EN,
	output logic                             O_CPU_CLK_RUN,
	output logic                             O_PERIPH_CLK_RUN,
	output logic                             O_SLOWDOWN_ACTIVE
);
	csic_ratio_if lnk ();

	logic                          idle_sel_q;
	logic                          slow_en_q;
	logic                          slow_en_d;
	logic                          irq_full_q;
	logic                          exit_slow_q;
	logic [csic_pkg::RATIO_W-1:0] ratio_q;
	logic [csic_pkg::RATIO_W-1:0] ratio_prev_q;
	logic                          eff_prev_q;
	csic_pkg::csic_state_t         state_q;
	csic_pkg::csic_state_t         state_d;
	logic [csic_pkg::DATA_W-1:0]  ctrl_val;

	wire ctrl_hit   = (I_ADDR == csic_pkg::CTRL_OFFSET);
	wire ctrl_wr    = I_WR && ctrl_hit;
	wire ctrl_rd    = I_RD && ctrl_hit;
	wire irq_clear  = I_IRQ_ENTRY && irq_full_q;              // [R4]
	wire ret_set    = I_RETURN_FROM_INTERRUPT && exit_slow_q; // [R5]
	// Debug overrides the throttle without touching the stored bit.
	wire slow_eff   = slow_en_q && !I_IN_CIRCUIT_DEBUG;       // [R7]
	wire running    = (state_q == csic_pkg::ST_RUN);

	// Bit 3 is unimplemented and reads as zero.
	assign ctrl_val = {idle_sel_q, slow_en_q, irq_full_q, exit_slow_q, 1'b0, ratio_q}; // [R8]

	// A hardware set beats a hardware clear, and both beat a software write in the same cycle.
	assign slow_en_d = ret_set   ? 1'b1 :                                 // [R5]
	                   irq_clear ? 1'b0 :                                 // [R4]
	                   ctrl_wr   ? I_WDATA[csic_pkg::BIT_SLOW_EN] : slow_en_q;

	assign lnk.enable  = slow_eff;                                        // [R2]
	assign lnk.ratio   = ratio_q;                                         // [R3]
	assign lnk.restart = (slow_eff && !eff_prev_q) || (ratio_q != ratio_prev_q); // [R9]

	csic_ratio_cnt u_cnt
	(
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.lnk     (lnk)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			csic_pkg::ST_RUN:
				if (I_SLEEP_EXEC)
					state_d = idle_sel_q ? csic_pkg::ST_IDLE : csic_pkg::ST_SLEEP; // [R1]
			csic_pkg::ST_IDLE,
			csic_pkg::ST_SLEEP:
				if (I_WAKE)
					state_d = csic_pkg::ST_RUN;
			default:
				state_d = csic_pkg::ST_RUN;
		endcase
	end

	// The idle bit survives ordinary resets so that software keeps its sleep choice.
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			if (I_POR_BOR)
				idle_sel_q <= csic_pkg::CTRL_RESET[csic_pkg::BIT_IDLE_SEL]; // [R8]
		end
		else if (ctrl_wr)
			idle_sel_q <= I_WDATA[csic_pkg::BIT_IDLE_SEL];
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			slow_en_q    <= csic_pkg::CTRL_RESET[csic_pkg::BIT_SLOW_EN];   // [R8]
			irq_full_q   <= csic_pkg::CTRL_RESET[csic_pkg::BIT_IRQ_FULL];
			exit_slow_q  <= csic_pkg::CTRL_RESET[csic_pkg::BIT_EXIT_SLOW];
			ratio_q      <= csic_pkg::CTRL_RESET[csic_pkg::RATIO_MSB:csic_pkg::RATIO_LSB];
			ratio_prev_q <= csic_pkg::CTRL_RESET[csic_pkg::RATIO_MSB:csic_pkg::RATIO_LSB];
			eff_prev_q   <= 1'b0;
			state_q      <= csic_pkg::ST_RUN;
		end
		else
		begin
			slow_en_q    <= slow_en_d;
			ratio_prev_q <= ratio_q;
			eff_prev_q   <= slow_eff;
			state_q      <= state_d;
			if (ctrl_wr)
			begin
				irq_full_q  <= I_WDATA[csic_pkg::BIT_IRQ_FULL];
				exit_slow_q <= I_WDATA[csic_pkg::BIT_EXIT_SLOW];
				ratio_q     <= I_WDATA[csic_pkg::RATIO_MSB:csic_pkg::RATIO_LSB];
			end
		end
	end

	// Outputs are registered, so they trail the counter and state by one cycle.
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			O_RDATA                   <= '0;
			O_CPU_EXEC_EN             <= 1'b0;
			O_PROGRAM_MEMORY_FETCH_EN <= 1'b0;
			O_CPU_CLK_RUN             <= 1'b0;
			O_PERIPH_CLK_RUN          <= 1'b0;
			O_SLOWDOWN_ACTIVE         <= 1'b0;
		end
		else
		begin
			O_RDATA                   <= ctrl_rd ? ctrl_val : '0;
			O_CPU_EXEC_EN             <= running && lnk.exec_cycle;       // [R2]
			O_PROGRAM_MEMORY_FETCH_EN <= running && lnk.fetch_cycle;      // [R6]
			O_CPU_CLK_RUN             <= running;                         // [R1]
			O_PERIPH_CLK_RUN          <= (state_q != csic_pkg::ST_SLEEP); // [R6]
			O_SLOWDOWN_ACTIVE         <= slow_eff;
		end
	end
endmodule
`default_nettype wire

// ### csic_properties.sv
/* Port assertions for the slowdown and idle control top.
   Assumes it is bound to csic_top and strobes stay low during reset. */
`timescale 1ns/100ps
`default_nettype none
module csic_props
(
	// Clock and reset
	input wire logic	I_CLK,
	input wire logic	I_RST_N,
	input wire logic	I_POR_BOR,
	// Register port
	input wire logic [3:0]	I_ADDR,
	input wire logic [7:0]	I_WDATA,
	input wire logic	I_WR,
	input wire logic	I_RD,
	input wire logic [7:0]	O_RDATA,
	// Core events and enables
	input wire logic	I_SLEEP_EXEC,
	input wire logic	I_WAKE,
	input wire logic	I_IRQ_ENTRY,
	input wire logic	I_RETURN_FROM_INTERRUPT,
	input wire logic	I_IN_CIRCUIT_DEBUG,
	input wire logic	O_CPU_EXEC_EN,
	input wire logic	O_CPU_CLK_RUN,
	input wire logic	O_PERIPH_CLK_RUN,
	input wire logic	O_SLOWDOWN_ACTIVE
);
	logic [3:0] ctl_q;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Shadow of bits 7..4 as last written by software; bit 7 outlives a reset that is neither power-on nor brown-out.
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
			ctl_q <= {ctl_q[3] & !I_POR_BOR, 3'h0};
		else if (I_WR && I_ADDR == 4'h0)
			ctl_q <= I_WDATA[7:4];
	chk_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
		else $error("read data outside a read");
	chk_read_fixed: assert property
		($past(I_RD) && $past(I_ADDR) == 4'h0 |-> O_RDATA[7] == $past(ctl_q[3]) && !O_RDATA[3])
		else $error("control read-back wrong");
	chk_debug_full: assert property ($past(I_IN_CIRCUIT_DEBUG) |-> !O_SLOWDOWN_ACTIVE)
		else $error("slowdown during debug");
	chk_full_speed: assert property
		(!O_SLOWDOWN_ACTIVE && $past(!O_SLOWDOWN_ACTIVE) && O_CPU_CLK_RUN && $past(O_CPU_CLK_RUN) |-> O_CPU_EXEC_EN)
		else $error("cycle skipped at full speed");
	chk_periph_run: assert property (O_CPU_CLK_RUN |-> O_PERIPH_CLK_RUN)
		else $error("peripheral clock stopped");
	chk_sleep_gate: assert property
		(I_SLEEP_EXEC && O_CPU_CLK_RUN ##1 !I_WAKE |-> ##1 !O_CPU_CLK_RUN && O_PERIPH_CLK_RUN == $past(ctl_q[3], 2))
		else $error("sleep gating wrong");
	chk_irq_clear: assert property
		(I_IRQ_ENTRY && ctl_q[1] && !I_RETURN_FROM_INTERRUPT
			##1 !I_RETURN_FROM_INTERRUPT && !I_WR |=> !O_SLOWDOWN_ACTIVE)
		else $error("interrupt entry kept slowdown");
	chk_ret_set: assert property
		(I_RETURN_FROM_INTERRUPT && ctl_q[0]
			##1 !I_IN_CIRCUIT_DEBUG && !I_IRQ_ENTRY && !I_WR |=> O_SLOWDOWN_ACTIVE)
		else $error("return did not set slowdown");
endmodule
`default_nettype wire

// ### csic_core_model.sv
/* Core and interrupt controller stand-in: turns a bench event code into one-cycle pulses.
   Assumes codes 1 sleep, 2 wake, 3 interrupt entry, 4 return, 0 none. */
`timescale 1ns/100ps
`default_nettype none
module csic_core_model
(
	// Clock
	input  wire logic       i_clk,
	// Event request
	input  wire logic [2:0] i_evt,
	// Pulses: return, entry, wake, sleep
	output logic      [3:0] o_pulse
);
	always_ff @(posedge i_clk)
		o_pulse <= (i_evt == 3'h0) ? 4'h0 : 4'h1 << (i_evt - 3'h1);
endmodule
`default_nettype wire

// ### tb_cpu_slowdown_idle_control.sv
/* Self-checking bench for the slowdown and idle control block.
   Assumes csic_top, the core event model and the property checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_slowdown_idle_control;
	logic       I_CLK, I_RST_N, I_POR_BOR, I_WR, I_RD, I_IN_CIRCUIT_DEBUG;
	logic [3:0] I_ADDR;
	logic [7:0] I_WDATA, O_RDATA, v;
	logic       I_SLEEP_EXEC, I_WAKE, I_IRQ_ENTRY, I_RETURN_FROM_INTERRUPT;
	logic       O_CPU_EXEC_EN, O_PROGRAM_MEMORY_FETCH_EN, O_CPU_CLK_RUN, O_PERIPH_CLK_RUN, O_SLOWDOWN_ACTIVE;
	logic [2:0] evt;
	logic [7:0] irq_w [4] = '{8'h60, 8'h40, 8'h10, 8'h00};
	logic [7:0] irq_x [4] = '{8'h20, 8'h40, 8'h50, 8'h00};
	logic [2:0] irq_e [4] = '{3'h3, 3'h3, 3'h4, 3'h4};
	int         bad_count, check_count, seed;
	csic_top dut_u
	(
		.I_CLK                     (I_CLK),
		.I_RST_N                   (I_RST_N),
		.I_POR_BOR                 (I_POR_BOR),
		.I_ADDR                    (I_ADDR),
		.I_WDATA                   (I_WDATA),
		.I_WR                      (I_WR),
		.I_RD                      (I_RD),
		.O_RDATA                   (O_RDATA),
		.I_SLEEP_EXEC              (I_SLEEP_EXEC),
		.I_WAKE                    (I_WAKE),
		.I_IRQ_ENTRY               (I_IRQ_ENTRY),
		.I_RETURN_FROM_INTERRUPT   (I_RETURN_FROM_INTERRUPT),
		.I_IN_CIRCUIT_DEBUG        (I_IN_CIRCUIT_DEBUG),
		.O_CPU_EXEC_EN             (O_CPU_EXEC_EN),
		.O_PROGRAM_MEMORY_FETCH_EN (O_PROGRAM_MEMORY_FETCH_EN),
		.O_CPU_CLK_RUN             (O_CPU_CLK_RUN),
		.O_PERIPH_CLK_RUN          (O_PERIPH_CLK_RUN),
		.O_SLOWDOWN_ACTIVE         (O_SLOWDOWN_ACTIVE)
	);
	csic_core_model model_u (.i_clk(I_CLK), .i_evt(evt),
		.o_pulse({I_RETURN_FROM_INTERRUPT, I_IRQ_ENTRY, I_WAKE, I_SLEEP_EXEC}));
	task automatic finish_test();
		$display("mismatches %0d, checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 chk({1'b0, O_RDATA}, {1'b0, e});
	endtask
	task automatic ev(input logic [2:0] c);
		@(posedge I_CLK);
		evt <= c;
		@(posedge I_CLK);
		evt <= 3'h0;
		repeat (4) @(posedge I_CLK);
		#1;
	endtask
	task automatic rst(input logic p);
		@(posedge I_CLK);
		I_POR_BOR <= p;
		I_RST_N <= 1'b0;
		repeat (8) @(posedge I_CLK);
		I_RST_N <= 1'b1;
	endtask
	// The ratio write restarts the counter, so two edges pass before timing starts.
	task automatic per(input int n);
		int   c;
		logic f;
		c = 0;
		repeat (2) @(posedge I_CLK);
		do
		begin
			@(posedge I_CLK);
			#1 c++;
		end
		while (O_CPU_EXEC_EN !== 1'b1 && c < 600);
		if (c > 599)
		begin
			bad_count++;
			finish_test();
		end
		c = 0;
		do
		begin
			f = O_PROGRAM_MEMORY_FETCH_EN;
			@(posedge I_CLK);
			#1 c++;
		end
		while (O_CPU_EXEC_EN !== 1'b1 && c < 600);
		if (c > 599)
		begin
			bad_count++;
			finish_test();
		end
		chk(c[8:0], n[8:0]);
		chk(f, 1'b1);
	endtask
	initial
	begin
		I_CLK = 1'b0;
		forever #25 I_CLK = ~I_CLK;
	end
	initial
	begin
		{I_RST_N, I_POR_BOR, I_WR, I_RD, I_IN_CIRCUIT_DEBUG, I_ADDR, I_WDATA, evt} = '0;
		bad_count = 0;
		check_count = 0;
		seed = 62;
		rst(1'b1);
		rd(4'h0, 8'h00);
		repeat (4)
		begin
			v = 8'($random(seed));
			wr(4'h0, v);
			rd(4'h0, v & 8'hf7);
			rd(v[3:0] | 4'h1, 8'h00);
		end
		for (int r = 0; r < 8; r++)
		begin
			wr(4'h0, 8'h40 | r[7:0]);
			per(2 << r);
		end
		@(posedge I_CLK);
		I_IN_CIRCUIT_DEBUG <= 1'b1;
		repeat (4) @(posedge I_CLK);
		#1 chk(O_CPU_EXEC_EN, 1'b1);
		chk(O_SLOWDOWN_ACTIVE, 1'b0);
		@(posedge I_CLK);
		I_IN_CIRCUIT_DEBUG <= 1'b0;
		rd(4'h0, 8'h47);
		chk(O_SLOWDOWN_ACTIVE, 1'b1);
		foreach (irq_w[i])
		begin
			wr(4'h0, irq_w[i]);
			ev(irq_e[i]);
			rd(4'h0, irq_x[i]);
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(4'h0, {k[0], 7'h00});
			ev(3'h1);
			chk(O_CPU_CLK_RUN, 1'b0);
			chk(O_PERIPH_CLK_RUN, k[0]);
			ev(3'h2);
			chk(O_CPU_CLK_RUN, 1'b1);
		end
		rst(1'b0);
		rd(4'h0, 8'h80);
		rst(1'b1);
		rd(4'h0, 8'h00);
		finish_test();
	end
endmodule
bind csic_top csic_props chk_u
(
	.I_CLK                   (I_CLK),
	.I_RST_N                 (I_RST_N),
	.I_POR_BOR               (I_POR_BOR),
	.I_ADDR                  (I_ADDR),
	.I_WDATA                 (I_WDATA),
	.I_WR                    (I_WR),
	.I_RD                    (I_RD),
	.O_RDATA                 (O_RDATA),
	.I_SLEEP_EXEC            (I_SLEEP_EXEC),
	.I_WAKE                  (I_WAKE),
	.I_IRQ_ENTRY             (I_IRQ_ENTRY),
	.I_RETURN_FROM_INTERRUPT (I_RETURN_FROM_INTERRUPT),
	.I_IN_CIRCUIT_DEBUG      (I_IN_CIRCUIT_DEBUG),
	.O_CPU_EXEC_EN           (O_CPU_EXEC_EN),
	.O_CPU_CLK_RUN           (O_CPU_CLK_RUN),
	.O_PERIPH_CLK_RUN        (O_PERIPH_CLK_RUN),
	.O_SLOWDOWN_ACTIVE       (O_SLOWDOWN_ACTIVE)
);
`default_nettype wire
